// ==== quad_all_lane_reg_id_cmd_decoder.sv ====
// Four-lane serial flash command decoder: ident, register reads, write
// enables and register write. Assumes the host drives dq on serial clock
// falling edges and that mclk runs at least four times the serial clock.
`default_nettype none
// How it works
// - opcode, address, data all on four lanes
// - 9F returns manufacturer and device ident
// - AF returns the same ident bytes
// - 5A plus three address bytes streams parameters
// - 4C returns 64-bit unique number
// - 05 returns status register one
// - 07 returns status register two
// - 35 returns configuration register one
// - 65 reads register, three or four address bytes
// - B7 sets, B8 clears address length bit
// - 06 sets write-enable latch
// - 50 enables volatile register writes
// - 04 clears write-enable latch
// - 01 loads status, then config one to four
module quad_all_lane_reg_id_cmd_decoder
  import qspi_cmd_pkg::*;
#(
  // Arbitrary values, not any real maker or part
  parameter logic [23:0] IDENT_BYTES = 24'h11_22_33,
  parameter logic [63:0] UNIQUE_ID   = 64'h0123_4567_89ab_cdef
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Serial link pins
  input  wire logic        sclk,
  input  wire logic        csB,
  input  wire logic [3:0]  dqIn,
  output logic      [3:0]  dqOut,
  output logic      [3:0]  dqOe,
  // Parameter table and second status register sources
  output logic      [31:0] paramAddr,
  input  wire logic [7:0]  paramData,
  input  wire logic [7:0]  statusTwo,
  // Register state
  output regset_t          regs,
  output logic             addrLength,
  output logic             volWriteEn
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic       sclkMeta_ff, sclkSync_ff, sclkLast_ff;
  logic       csMeta_ff, csSync_ff, csLast_ff;
  logic [3:0] dqMeta_ff, dqSync_ff;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {sclkLast_ff, sclkSync_ff, sclkMeta_ff} <= 3'b000;
      {csLast_ff, csSync_ff, csMeta_ff}       <= 3'b111;
      {dqSync_ff, dqMeta_ff}                  <= 8'h00;
    end else begin
      {sclkLast_ff, sclkSync_ff} <= {sclkSync_ff, sclkMeta_ff};
      {csLast_ff, csSync_ff}     <= {csSync_ff, csMeta_ff};
      {dqSync_ff, dqMeta_ff}     <= {dqMeta_ff, dqIn};
      sclkMeta_ff                <= sclk;
      csMeta_ff                  <= csB;
    end
  end
  wire sclkRise = sclkSync_ff & ~sclkLast_ff & ~csSync_ff;
  wire sclkFall = ~sclkSync_ff & sclkLast_ff & ~csSync_ff;
  wire frameEnd = csSync_ff & ~csLast_ff;
  // ****************************************************************
  // Command decode
  // ****************************************************************
  state_t      state_ff, nxt_state;
  logic        nib_ff, outPhase_ff, wrote_ff, volEn_ff, oe_ff;
  logic [3:0]  shift_ff, cnt_ff, nxt_cnt, dqOut_ff;
  logic [7:0]  cmd_ff;
  logic [31:0] addr_ff, idx_ff;
  regset_t     regs_ff;
  // Four lanes: one byte is two nibbles, high first
  wire       byteDone = sclkRise & nib_ff;
  wire [7:0] fullByte = {shift_ff, dqSync_ff};
  wire       welSet   = regs_ff.statusOne[WEL_POS];
  wire       isIdent  = (fullByte == OP_READ_IDENT) |
                        (fullByte == OP_READ_IDENT_Q);
  wire       isRegRd  = (fullByte == OP_READ_UNIQUE) |
                        (fullByte == OP_READ_STAT1) |
                        (fullByte == OP_READ_STAT2) |
                        (fullByte == OP_READ_CFG1);
  wire       isAddrRd = (fullByte == OP_READ_PARAM) |
                        (fullByte == OP_READ_ANY);
  wire       opcDone  = byteDone & (state_ff == ST_OPC);
  wire [3:0] addrBytes = ((cmd_ff == OP_READ_ANY) & addrLength) ?
                         LONG_ADDR_BYTES : SHORT_ADDR_BYTES;
  wire       addrLast = byteDone & (state_ff == ST_ADDR) &
                        (cnt_ff == addrBytes - 4'h1);
  wire       wrByte   = byteDone & (state_ff == ST_WRITE);
  wire       outStep  = sclkFall & (state_ff == ST_READ);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    if (byteDone) begin
      nxt_cnt = cnt_ff + 4'h1;
      case (state_ff)
        ST_OPC: begin
          nxt_cnt = 4'h0;
          if (isIdent | isRegRd)
            nxt_state = ST_READ;
          else if (isAddrRd)
            nxt_state = ST_ADDR;
          else if ((fullByte == OP_WRITE_REGS) & (welSet | volEn_ff))
            nxt_state = ST_WRITE;
          else
            nxt_state = ST_SKIP;
        end
        ST_ADDR: begin
          if (addrLast)
            nxt_state = ST_READ;
        end
        ST_WRITE: begin
          if (cnt_ff == WRITE_BYTES - 4'h1)
            nxt_state = ST_SKIP;
        end
        default: nxt_cnt = cnt_ff;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_OPC;
      nib_ff   <= 1'b0;
      shift_ff <= 4'h0;
      cmd_ff   <= 8'h00;
      cnt_ff   <= 4'h0;
      addr_ff  <= 32'h0;
      idx_ff   <= 32'h0;
    end else if (csSync_ff) begin
      state_ff <= ST_OPC;
      nib_ff   <= 1'b0;
      cnt_ff   <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      if (sclkRise) begin
        nib_ff   <= ~nib_ff;
        shift_ff <= dqSync_ff;
      end
      if (opcDone) begin
        cmd_ff  <= fullByte;
        addr_ff <= 32'h0;
        idx_ff  <= 32'h0;
      end else if (byteDone & (state_ff == ST_ADDR)) begin
        addr_ff <= {addr_ff[23:0], fullByte};
        if (addrLast)
          idx_ff <= {addr_ff[23:0], fullByte};
      end else if (outStep & outPhase_ff) begin
        idx_ff <= idx_ff + 32'h1;
      end
    end
  end

  // ****************************************************************
  // Register state
  // ****************************************************************
  // Writes land byte by byte; the latch drops when the write frame ends
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      regs_ff  <= '{SR1_RST, CR1_RST, CR2_RST, CR3_RST, CR4_RST};
      volEn_ff <= 1'b0;
      wrote_ff <= 1'b0;
    end else begin
      if (opcDone)
        wrote_ff <= 1'b0;
      if (wrByte) begin
        wrote_ff <= 1'b1;
        case (cnt_ff)
          4'h0: regs_ff.statusOne <= {fullByte[7:WEL_POS+1], welSet,
                                      fullByte[WEL_POS-1:0]};
          4'h1: regs_ff.configOne   <= fullByte;
          4'h2: regs_ff.configTwo   <= fullByte;
          4'h3: regs_ff.configThree <= fullByte;
          default: regs_ff.configFour <= fullByte;
        endcase
      end
      if (opcDone & (fullByte == OP_LONG_ADDR))
        regs_ff.configTwo[ADDR_LEN_POS] <= 1'b1;
      if (opcDone & (fullByte == OP_SHORT_ADDR))
        regs_ff.configTwo[ADDR_LEN_POS] <= 1'b0;
      if (frameEnd & wrote_ff) begin
        regs_ff.statusOne[WEL_POS] <= 1'b0;
        volEn_ff <= 1'b0;
      end
      if (opcDone & (fullByte == OP_WRDIS))
        regs_ff.statusOne[WEL_POS] <= 1'b0;
      if (opcDone & (fullByte == OP_WREN_VOL))
        volEn_ff <= 1'b1;
      // Placed last so a set is never lost to a same-cycle clear
      if (opcDone & (fullByte == OP_WREN))
        regs_ff.statusOne[WEL_POS] <= 1'b1;
    end
  end
  assign regs       = regs_ff;
  assign addrLength = regs_ff.configTwo[ADDR_LEN_POS];
  assign volWriteEn = volEn_ff;
  assign paramAddr  = idx_ff;
  // ****************************************************************
  // Read data path
  // ****************************************************************
  function automatic logic [7:0] anyReg(input logic [7:0] ra,
                                        input regset_t rs,
                                        input logic [7:0] st2);
    if (ra == RA_SR1)      return rs.statusOne;
    else if (ra == RA_SR2) return st2;
    else if (ra == RA_CR1) return rs.configOne;
    else if (ra == RA_CR2) return rs.configTwo;
    else if (ra == RA_CR3) return rs.configThree;
    else if (ra == RA_CR4) return rs.configFour;
    else                   return 8'h00;
  endfunction
  logic [7:0] curByte;
  always_comb begin
    case (cmd_ff)
      OP_READ_IDENT, OP_READ_IDENT_Q:
        curByte = (idx_ff < 32'h3) ?
          IDENT_BYTES[8'(23 - 8 * idx_ff[1:0]) -: 8] : 8'h00;
      OP_READ_UNIQUE:
        curByte = UNIQUE_ID[8'(63 - 8 * idx_ff[2:0]) -: 8];
      OP_READ_STAT1:  curByte = regs_ff.statusOne;
      OP_READ_STAT2:  curByte = statusTwo;
      OP_READ_CFG1:   curByte = regs_ff.configOne;
      OP_READ_PARAM:  curByte = paramData;
      OP_READ_ANY:    curByte = anyReg(idx_ff[7:0], regs_ff, statusTwo);
      default:        curByte = 8'h00;
    endcase
  end
  // Nibbles change on falling edges so the host samples a settled value
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      outPhase_ff <= 1'b0;
      dqOut_ff    <= 4'h0;
      oe_ff       <= 1'b0;
    end else if (csSync_ff) begin
      outPhase_ff <= 1'b0;
      oe_ff       <= 1'b0;
    end else if (outStep) begin
      outPhase_ff <= ~outPhase_ff;
      oe_ff       <= 1'b1;
      dqOut_ff    <= outPhase_ff ? curByte[3:0] : curByte[7:4];
    end
  end
  assign dqOut = dqOut_ff;
  assign dqOe  = {4{oe_ff}};
  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_wel_set_06: assert property (opcDone && fullByte == OP_WREN
    |=> regs.statusOne[WEL_POS]) else $error("06 left latch clear");
  a_wel_clear_04: assert property (opcDone && fullByte == OP_WRDIS
    |=> !regs.statusOne[WEL_POS]) else $error("04 left latch set");
  a_addr_len_on: assert property (opcDone && fullByte == OP_LONG_ADDR
    |=> addrLength) else $error("B7 did not set length");
  a_addr_len_off: assert property (opcDone && fullByte == OP_SHORT_ADDR
    |=> !addrLength) else $error("B8 did not clear length");
  a_vol_enable: assert property (opcDone && fullByte == OP_WREN_VOL
    |=> volWriteEn) else $error("50 did not enable");
  a_write_blocked: assert property (opcDone && fullByte == OP_WRITE_REGS
    && !welSet && !volEn_ff |=> state_ff == ST_SKIP)
    else $error("write taken without enable");
  a_skip_keeps_regs: assert property (state_ff == ST_SKIP && byteDone
    && cmd_ff == OP_WRITE_REGS |=> $stable(regs))
    else $error("ignored write changed register");
  a_cfg_one_order: assert property (wrByte && cnt_ff == 4'h1
    |=> regs.configOne == $past(fullByte))
    else $error("second data byte not in config one");
  a_ident_read: assert property (opcDone && isIdent
    |=> state_ff == ST_READ && idx_ff == 32'h0)
    else $error("ident read not started");
  a_any_len: assert property (byteDone && state_ff == ST_ADDR
    && cmd_ff == OP_READ_ANY && cnt_ff == 4'h2 && addrLength
    |=> state_ff == ST_ADDR) else $error("long address cut short");
  a_status_out: assert property (outStep && !outPhase_ff
    && cmd_ff == OP_READ_STAT1 && !csSync_ff
    |=> dqOut == $past(regs.statusOne[7:4]) && dqOe == 4'hf)
    else $error("status high nibble wrong");
  a_oe_in_read: assert property (dqOe != 4'h0 |-> state_ff == ST_READ)
    else $error("lanes driven outside read");

  c_ident: cover property (opcDone && fullByte == OP_READ_IDENT);
  c_any_long: cover property (addrLast && addrLength);
  c_write_all: cover property (wrByte && cnt_ff == 4'h4);
endmodule // quad_all_lane_reg_id_cmd_decoder
`default_nettype wire

// ==== qspi_cmd_pkg.sv ====
// Constants and types for the four-lane register and ident command decoder.
// Assumes a single system clock well above the serial clock rate.
`default_nettype none
package qspi_cmd_pkg;
  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OP_READ_IDENT   = 8'h9f;
  localparam logic [7:0] OP_READ_IDENT_Q = 8'haf;
  localparam logic [7:0] OP_READ_PARAM   = 8'h5a;
  localparam logic [7:0] OP_READ_UNIQUE  = 8'h4c;
  localparam logic [7:0] OP_READ_STAT1   = 8'h05;
  localparam logic [7:0] OP_READ_STAT2   = 8'h07;
  localparam logic [7:0] OP_READ_CFG1    = 8'h35;
  localparam logic [7:0] OP_READ_ANY     = 8'h65;
  localparam logic [7:0] OP_WREN         = 8'h06;
  localparam logic [7:0] OP_WREN_VOL     = 8'h50;
  localparam logic [7:0] OP_WRDIS        = 8'h04;
  localparam logic [7:0] OP_WRITE_REGS   = 8'h01;
  localparam logic [7:0] OP_LONG_ADDR    = 8'hb7;
  localparam logic [7:0] OP_SHORT_ADDR   = 8'hb8;
  // ****************************************************************
  // Field positions, reset values, read-any addresses
  // ****************************************************************
  localparam int         WEL_POS      = 1;
  localparam int         ADDR_LEN_POS = 7;
  localparam logic [7:0] SR1_RST      = 8'h00;
  localparam logic [7:0] CR1_RST      = 8'h00;
  localparam logic [7:0] CR2_RST      = 8'h00;
  localparam logic [7:0] CR3_RST      = 8'h00;
  localparam logic [7:0] CR4_RST      = 8'h00;
  localparam logic [7:0] RA_SR1       = 8'h00;
  localparam logic [7:0] RA_SR2       = 8'h01;
  localparam logic [7:0] RA_CR1       = 8'h02;
  localparam logic [7:0] RA_CR2       = 8'h03;
  localparam logic [7:0] RA_CR3       = 8'h04;
  localparam logic [7:0] RA_CR4       = 8'h05;
  localparam logic [3:0] SHORT_ADDR_BYTES = 4'h3;
  localparam logic [3:0] LONG_ADDR_BYTES  = 4'h4;
  localparam logic [3:0] WRITE_BYTES      = 4'h5;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] statusOne;
    logic [7:0] configOne;
    logic [7:0] configTwo;
    logic [7:0] configThree;
    logic [7:0] configFour;
  } regset_t;
  typedef enum {ST_OPC, ST_ADDR, ST_READ, ST_WRITE, ST_SKIP} state_t;
endpackage
`default_nettype wire

// ==== qspi_host_model.sv ====
// Quad SPI host model: frames carry opcode, address and data on four lanes.
// Assumes the bench clock mclk; one serial period is 16 mclk (64 ns).
`default_nettype none
module qspi_host_model (
  // Clock
  input  wire logic       mclk,
  // Serial link
  output logic            sclk,
  output logic            csB,
  output logic      [3:0] dqIn,
  input  wire logic [3:0] dqOut,
  input  wire logic [3:0] dqOe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk = 1'b0;
    csB  = 1'b1;
    dqIn = 4'h0;
  end

  // ****************************************************************
  // Nibble and frame
  // ****************************************************************
  // Lanes change with the fall; released lanes toggle so no stale value
  task automatic nib(input logic drv, input logic [3:0] v,
                     output logic [3:0] got);
    @(posedge mclk);
    sclk <= 1'b0;
    dqIn <= drv ? v : ~dqIn;
    repeat (8) @(posedge mclk);
    sclk <= 1'b1;
    repeat (7) @(posedge mclk);
    got = (dqOe === 4'hf) ? dqOut : 4'hx;
  endtask

  task automatic frame(input logic [7:0] tx[$], input int nRx,
                       output logic [7:0] rx[$]);
    logic [3:0] hi;
    logic [3:0] lo;
    rx = {};
    @(posedge mclk);
    csB <= 1'b0;
    repeat (4) @(posedge mclk);
    foreach (tx[i]) begin
      nib(1'b1, tx[i][7:4], hi);
      nib(1'b1, tx[i][3:0], lo);
    end
    repeat (nRx) begin
      nib(1'b0, 4'h0, hi);
      nib(1'b0, 4'h0, lo);
      rx.push_back({hi, lo});
    end
    @(posedge mclk);
    sclk <= 1'b0;
    repeat (4) @(posedge mclk);
    csB  <= 1'b1;
    dqIn <= ~dqIn;
    repeat (8) @(posedge mclk);
  endtask
endmodule // qspi_host_model
`default_nettype wire

// ==== quad_all_lane_reg_id_cmd_decoder_tb.sv ====
// Self-checking bench for the four-lane command decoder.
// Assumes the host model drives the link; register expectations come from ra[].
`default_nettype none
module quad_all_lane_reg_id_cmd_decoder_tb;
  import qspi_cmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // Arbitrary values, not any real part
  localparam logic [23:0] IDV = 24'h11_22_33;
  localparam logic [63:0] UID = 64'h0123_4567_89ab_cdef;

  logic        mclk, rst_b, sclk, csB;
  logic [3:0]  dqIn, dqOut, dqOe;
  logic [31:0] paramAddr;
  logic [7:0]  paramData, statusTwo;
  regset_t     regs;
  logic        addrLength, volWriteEn;
  logic [7:0]  rx[$], q[$], w[$];
  int          failures, compares, ven, a;
  int          ra[6];

  quad_all_lane_reg_id_cmd_decoder #(.IDENT_BYTES(IDV), .UNIQUE_ID(UID)) uut (
    .mclk(mclk), .rst_b(rst_b), .sclk(sclk), .csB(csB), .dqIn(dqIn),
    .dqOut(dqOut), .dqOe(dqOe), .paramAddr(paramAddr),
    .paramData(paramData), .statusTwo(statusTwo), .regs(regs),
    .addrLength(addrLength), .volWriteEn(volWriteEn));

  qspi_host_model host (.mclk(mclk), .sclk(sclk), .csB(csB), .dqIn(dqIn),
                        .dqOut(dqOut), .dqOe(dqOe));

  always #2 mclk = ~mclk;
  always @(posedge mclk) paramData <= paramAddr[7:0] ^ 8'h5c;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkRegs();
    chk(regs, {ra[0][7:0], ra[2][7:0], ra[3][7:0], ra[4][7:0], ra[5][7:0]});
    chk(addrLength, ra[3][7]);
    chk(volWriteEn, ven);
  endtask

  task automatic rd(input logic [7:0] tx[$], input logic [7:0] exp[$]);
    host.frame(tx, exp.size(), rx);
    foreach (exp[i]) chk(rx[i], exp[i]);
  endtask

  task automatic cmd(input logic [7:0] tx[$]);
    host.frame(tx, 0, rx);
  endtask

  task automatic newData();
    w = {8'h01};
    repeat (5) w.push_back(8'($urandom));
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    summarize();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    statusTwo = 8'h00;
    failures = 0;
    compares = 0;
    ven = 0;
    foreach (ra[i]) ra[i] = 0;
    void'($urandom(32'hf2f1));
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    ra[1] = $urandom % 256;
    statusTwo <= 8'(ra[1]);
    repeat (6) @(posedge mclk);
    chkRegs();
    rd('{OP_READ_IDENT}, '{IDV[23:16], IDV[15:8], IDV[7:0], 8'h00});
    rd('{OP_READ_IDENT_Q}, '{IDV[23:16], IDV[15:8], IDV[7:0]});
    q = {};
    for (int i = 0; i < 9; i++) q.push_back(UID[63 - 8 * (i % 8) -: 8]);
    rd('{OP_READ_UNIQUE}, q);
    newData();
    cmd(w);
    chkRegs();
    cmd('{OP_WREN});
    ra[0] = ra[0] | 2;
    chkRegs();
    rd('{OP_READ_STAT1}, '{8'(ra[0]), 8'(ra[0])});
    cmd('{OP_WRDIS});
    ra[0] = ra[0] & 8'hfd;
    chkRegs();
    for (int k = 0; k < 2; k++) begin
      cmd('{k ? OP_WREN_VOL : OP_WREN});
      ven = k;
      chk(volWriteEn, ven);
      newData();
      cmd(w);
      ra[0] = w[1] & 8'hfd;
      for (int i = 2; i < 6; i++) ra[i] = w[i];
      ven = 0;
      chkRegs();
    end
    rd('{OP_READ_CFG1}, '{8'(ra[2])});
    rd('{OP_READ_STAT2}, '{8'(ra[1])});
    for (int k = 0; k < 2; k++) begin
      cmd('{k ? OP_SHORT_ADDR : OP_LONG_ADDR});
      ra[3][7] = ~k[0];
      chkRegs();
      a = $urandom % 5;
      q = {OP_READ_ANY, 8'h00, 8'h00, 8'(a)};
      if (k == 0) q.insert(1, 8'h00);
      rd(q, '{8'(ra[a]), 8'(ra[a + 1])});
    end
    a = $urandom % 24'hffffff;
    q = '{OP_READ_PARAM, 8'(a >> 16), 8'(a >> 8), 8'(a)};
    w = {};
    for (int i = 0; i < 4; i++) w.push_back(8'(a + i) ^ 8'h5c);
    rd(q, w);
    chk(paramAddr, a + 4);
    summarize();
  end
endmodule // quad_all_lane_reg_id_cmd_decoder_tb
`default_nettype wire
